//--- cvu_pkg.sv
// shared constants and types for the context switch and vector unit
`default_nettype none
package cvu_pkg;

  // widths
  localparam int WORD_W = 16;
  localparam int WADDR_W = 15;
  localparam int NUM_LEVELS = 16;
  localparam int NUM_W = 4;

  // vector placement, byte addresses
  localparam logic [15:0] INT_VEC_BASE = 16'h0000;
  localparam logic [15:0] TRAP_VEC_BASE = 16'h0040;
  localparam logic [15:0] LOAD_VEC_ADDR = 16'hFFFC;
  localparam logic [15:0] VEC_PC_OFS = 16'h0002;
  localparam int VEC_PAIR_SHIFT = 2;
  localparam int REG_SHIFT = 1;

  // workspace register slots
  localparam logic [3:0] REG_ZERO = 4'h0;
  localparam logic [3:0] REG_LINK = 4'hB;
  localparam logic [3:0] REG_OLD_WP = 4'hD;
  localparam logic [3:0] REG_OLD_PC = 4'hE;
  localparam logic [3:0] REG_OLD_PSW = 4'hF;

  // status word layout
  localparam int PSW_MASK_LSB = 0;
  localparam int PSW_MASK_W = 4;
  localparam int SHIFT_CNT_W = 4;
  localparam int BYTE_W = 8;
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [3:0] LEVEL_STEP = 4'h1;

  // reset values
  localparam logic [15:0] RESET_WP = 16'h0000;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] RESET_PSW = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  typedef enum logic [3:0] {
    OP_BRANCH,
    OP_BRANCH_AND_LINK,
    OP_BRANCH_LOAD_WORKSPACE,
    OP_RETURN_RESTORE_WORKSPACE,
    OP_EXTENDED_OPERATION_TRAP,
    OP_BYTE_READ,
    OP_SHIFT_COUNT,
    OP_INDEX,
    OP_INTERRUPT,
    OP_LOAD_TRAP
  } cvu_op_t;

  typedef struct packed {
    cvu_op_t op;
    logic [15:0] target;
    logic [15:0] aux;
    logic [3:0] num;
    logic src_is_reg;
    logic [3:0] src_reg;
  } cvu_cmd_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [14:0] addr;
    logic [15:0] wdata;
  } cvu_mem_t;

endpackage
`default_nettype wire

//--- cvu_reg_addr.sv
// memory address of a workspace register
`timescale 1ns/1ps
`default_nettype none
module cvu_reg_addr
  import cvu_pkg::*;
(
  // workspace base and slot
  input wire logic [15:0] wp_in,
  input wire logic [3:0] n_in,
  // byte address of the slot
  output logic [15:0] addr_out
);

  // one word per register
  assign addr_out = wp_in + (16'(n_in) << REG_SHIFT);

endmodule
`default_nettype wire

//--- cvu_int_arb.sv
// interrupt request synchroniser and priority arbiter
`timescale 1ns/1ps
`default_nettype none
module cvu_int_arb
  import cvu_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // requests and mask
  input wire logic [15:0] req_in,
  input wire logic reset_pend_in,
  input wire logic [3:0] mask_in,
  // winner
  output logic valid_out,
  output logic [3:0] level_out
);

  logic [15:0] req_s1;
  logic [15:0] req_s2;
  logic [3:0] first;
  logic any;

  function automatic logic [3:0] first_set(input logic [15:0] v);
    first_set = LEVEL_RESET;
    for (int i = NUM_LEVELS - 1; i >= 0; i--)
    begin
      if (v[i])
        first_set = 4'(i);
    end
  endfunction

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      req_s1 <= ZERO_WORD;
      req_s2 <= ZERO_WORD;
    end
    else
    begin
      req_s1 <= req_in;
      req_s2 <= req_s1;
    end
  end

  // lowest number wins
  assign first = first_set(req_s2);
  assign any = |req_s2;
  // level zero always passes the compare
  assign valid_out = reset_pend_in | (any & (first <= mask_in));
  assign level_out = reset_pend_in ? LEVEL_RESET : first;

endmodule
`default_nettype wire

//--- cvu_core.sv
// context switch, vector and linkage sequencer
`timescale 1ns/1ps
`default_nettype none
module cvu_core (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // command from the instruction engine
  input wire logic CMD_VALID_IN,
  input wire cvu_pkg::cvu_cmd_t CMD_IN,
  output logic CMD_READY_OUT,
  output logic DONE_OUT,
  output logic [15:0] RESULT_OUT,
  output logic ERR_OUT,
  // event pins
  input wire logic [15:0] INT_REQ_IN,
  input wire logic LOAD_REQ_IN,
  // word memory
  output var cvu_pkg::cvu_mem_t MEM_OUT,
  input wire logic MEM_ACK_IN,
  input wire logic [15:0] MEM_RDATA_IN,
  // processor state
  output logic [15:0] WORKSPACE_PTR_OUT,
  output logic [15:0] PROGRAM_COUNTER_OUT,
  output logic [15:0] PROCESSOR_STATUS_WORD_OUT
);
  import cvu_pkg::*;

  typedef enum {
    S_IDLE, S_VEC_WP, S_VEC_PC, S_SAVE_WP, S_SAVE_PC, S_SAVE_PSW, S_SAVE_LNK,
    S_RET_WP, S_RET_PC, S_RET_PSW, S_OPER
  } cvu_state_t;

  function automatic logic [15:0] vec_of(input logic [15:0] base, input logic [3:0] n);
    vec_of = base + (16'(n) << VEC_PAIR_SHIFT);
  endfunction

  function automatic logic [15:0] byte_of(input logic [15:0] w, input logic odd);
    byte_of = odd ? {8'h00, w[BYTE_W-1:0]} : {8'h00, w[WORD_W-1:BYTE_W]};
  endfunction

  cvu_state_t state, next_state, cmd_state;
  cvu_op_t kind;
  logic [15:0] wp, pc, psw, new_wp, new_pc, target, aux, result;
  logic [3:0] num, lvl;
  logic reset_pend, load_s1, load_s2, load_s3, load_pend, done, err;

  logic idle, int_valid, take_load, take_int, cmd_go, idx_err, ack, save_st, commit, finish;
  logic [3:0] int_lvl, reg_n, mask;
  logic [15:0] reg_base, reg_addr, src_reg_addr, int_vec, xop_vec, start_target, start_aux;
  logic [15:0] mem_byte_addr, mem_wdata, psw_after_int, oper_result;
  logic load_rise;

  assign mask = psw[PSW_MASK_LSB +: PSW_MASK_W];

  cvu_int_arb u_arb (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .req_in(INT_REQ_IN),
    .reset_pend_in(reset_pend),
    .mask_in(mask),
    .valid_out(int_valid),
    .level_out(int_lvl)
  );

  // priority: reset, then load, then maskable levels, then commands
  assign idle = (state == S_IDLE);
  assign load_rise = load_s2 & ~load_s3;
  assign take_load = idle & load_pend & ~(int_valid & (int_lvl == LEVEL_RESET));
  assign take_int = idle & int_valid & ~take_load;
  assign CMD_READY_OUT = idle & ~load_pend & ~int_valid;
  assign cmd_go = CMD_VALID_IN & CMD_READY_OUT;
  assign idx_err = cmd_go & (CMD_IN.op == OP_INDEX) & (CMD_IN.num == REG_ZERO);

  // vector addresses
  assign int_vec = vec_of(INT_VEC_BASE, int_lvl);
  assign xop_vec = vec_of(TRAP_VEC_BASE, CMD_IN.num);
  assign start_target = take_load ? LOAD_VEC_ADDR :
                        take_int ? int_vec :
                        (CMD_IN.op == OP_EXTENDED_OPERATION_TRAP) ? xop_vec : CMD_IN.target;
  // register operand becomes its memory address
  assign start_aux = (CMD_IN.op == OP_EXTENDED_OPERATION_TRAP && CMD_IN.src_is_reg) ?
                     src_reg_addr : CMD_IN.aux;

  cvu_reg_addr u_src (
    .wp_in(wp),
    .n_in(CMD_IN.src_reg),
    .addr_out(src_reg_addr)
  );

  // register slot for the current step
  assign save_st = (state == S_SAVE_WP) || (state == S_SAVE_PC) ||
                   (state == S_SAVE_PSW) || (state == S_SAVE_LNK);
  assign reg_base = (save_st && kind != OP_BRANCH_AND_LINK) ? new_wp : wp;
  assign reg_n = (state == S_SAVE_WP || state == S_RET_WP) ? REG_OLD_WP :
                 (state == S_SAVE_PC || state == S_RET_PC) ? REG_OLD_PC :
                 (state == S_SAVE_PSW || state == S_RET_PSW) ? REG_OLD_PSW :
                 (state == S_SAVE_LNK) ? REG_LINK :
                 (kind == OP_SHIFT_COUNT) ? REG_ZERO : num;

  cvu_reg_addr u_slot (
    .wp_in(reg_base),
    .n_in(reg_n),
    .addr_out(reg_addr)
  );

  assign mem_byte_addr = (state == S_VEC_WP) ? target :
                         (state == S_VEC_PC) ? target + VEC_PC_OFS :
                         (state == S_OPER && kind == OP_BYTE_READ) ? target : reg_addr;
  assign mem_wdata = (state == S_SAVE_WP) ? wp :
                     (state == S_SAVE_PC) ? pc :
                     (state == S_SAVE_PSW) ? psw : aux;
  // whole words only; bit 0 selects the byte inside
  // one driver for the whole struct, so no field is driven twice
  assign MEM_OUT = '{req: ~idle, we: save_st, addr: mem_byte_addr[WORD_W-1:1], wdata: mem_wdata};
  assign ack = ~idle & MEM_ACK_IN;

  assign commit = ack & ((state == S_SAVE_PSW && kind != OP_EXTENDED_OPERATION_TRAP) ||
                         state == S_SAVE_LNK);
  assign finish = commit | (ack & (state == S_RET_PSW || state == S_OPER)) |
                  (cmd_go & (CMD_IN.op == OP_BRANCH)) | idx_err;
  // mask drops to one below the level taken, and stays at zero when level zero is taken
  assign psw_after_int = {psw[WORD_W-1:PSW_MASK_W],
                          (lvl == LEVEL_RESET) ? LEVEL_RESET : 4'(lvl - LEVEL_STEP)};
  assign oper_result = (kind == OP_BYTE_READ) ? byte_of(MEM_RDATA_IN, target[0]) :
                       (kind == OP_SHIFT_COUNT) ? 16'(MEM_RDATA_IN[SHIFT_CNT_W-1:0]) :
                       target + MEM_RDATA_IN;

  always_comb
  begin
    case (CMD_IN.op)
      OP_BRANCH_AND_LINK: cmd_state = S_SAVE_LNK;
      OP_BRANCH_LOAD_WORKSPACE: cmd_state = S_VEC_WP;
      OP_EXTENDED_OPERATION_TRAP: cmd_state = S_VEC_WP;
      OP_RETURN_RESTORE_WORKSPACE: cmd_state = S_RET_WP;
      OP_BYTE_READ: cmd_state = S_OPER;
      OP_SHIFT_COUNT: cmd_state = S_OPER;
      OP_INDEX: cmd_state = idx_err ? S_IDLE : S_OPER;
      default: cmd_state = S_IDLE;
    endcase
  end

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (take_load || take_int)
          next_state = S_VEC_WP;
        else if (cmd_go)
          next_state = cmd_state;
      end
      S_VEC_WP: if (ack) next_state = S_VEC_PC;
      S_VEC_PC: if (ack) next_state = S_SAVE_WP;
      S_SAVE_WP: if (ack) next_state = S_SAVE_PC;
      S_SAVE_PC: if (ack) next_state = S_SAVE_PSW;
      S_SAVE_PSW: if (ack) next_state = (kind == OP_EXTENDED_OPERATION_TRAP) ? S_SAVE_LNK : S_IDLE;
      S_SAVE_LNK: if (ack) next_state = S_IDLE;
      S_RET_WP: if (ack) next_state = S_RET_PC;
      S_RET_PC: if (ack) next_state = S_RET_PSW;
      S_RET_PSW: if (ack) next_state = S_IDLE;
      S_OPER: if (ack) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // load pin: two stage sync, then edge; a new edge beats the clear
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      load_s1 <= 1'b0;
      load_s2 <= 1'b0;
      load_s3 <= 1'b0;
      load_pend <= 1'b0;
      reset_pend <= 1'b1;
    end
    else
    begin
      load_s1 <= LOAD_REQ_IN;
      load_s2 <= load_s1;
      load_s3 <= load_s2;
      load_pend <= load_rise | (load_pend & ~take_load);
      reset_pend <= reset_pend & ~(take_int & (int_lvl == LEVEL_RESET));
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      kind <= OP_BRANCH;
      target <= ZERO_WORD;
      aux <= ZERO_WORD;
      num <= REG_ZERO;
      lvl <= LEVEL_RESET;
      new_wp <= ZERO_WORD;
      new_pc <= ZERO_WORD;
    end
    else
    begin
      if (take_load || take_int || cmd_go)
      begin
        kind <= take_load ? OP_LOAD_TRAP : take_int ? OP_INTERRUPT : CMD_IN.op;
        target <= start_target;
        aux <= start_aux;
        num <= CMD_IN.num;
        lvl <= int_lvl;
      end
      if (ack && (state == S_VEC_WP || state == S_RET_WP))
        new_wp <= MEM_RDATA_IN;
      if (ack && (state == S_VEC_PC || state == S_RET_PC))
        new_pc <= MEM_RDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      wp <= RESET_WP;
      pc <= RESET_PC;
      psw <= RESET_PSW;
    end
    else if (cmd_go && CMD_IN.op == OP_BRANCH)
      pc <= CMD_IN.target;
    else if (commit && kind == OP_BRANCH_AND_LINK)
      pc <= target;
    else if (commit)
    begin
      wp <= new_wp;
      pc <= new_pc;
      psw <= (kind == OP_INTERRUPT) ? psw_after_int : psw;
    end
    else if (ack && state == S_RET_PSW)
    begin
      wp <= new_wp;
      pc <= new_pc;
      psw <= MEM_RDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      done <= 1'b0;
      err <= 1'b0;
      result <= ZERO_WORD;
    end
    else
    begin
      done <= finish;
      err <= idx_err;
      if (ack && state == S_OPER)
        result <= oper_result;
    end
  end

  assign DONE_OUT = done;
  assign ERR_OUT = err;
  assign RESULT_OUT = result;
  assign WORKSPACE_PTR_OUT = wp;
  assign PROGRAM_COUNTER_OUT = pc;
  assign PROCESSOR_STATUS_WORD_OUT = psw;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  property p_byte_pick;
    (ack && state == S_OPER && kind == OP_BYTE_READ) |=>
      RESULT_OUT == byte_of($past(MEM_RDATA_IN), $past(target[0]));
  endproperty
  a_byte_pick: assert property (p_byte_pick) else $error("byte not picked from word");

  property p_int_vec;
    (state == S_VEC_WP && kind == OP_INTERRUPT) |-> MEM_OUT.addr == 15'({lvl, 1'b0});
  endproperty
  a_int_vec: assert property (p_int_vec) else $error("interrupt vector address wrong");

  property p_reset_level;
    (take_int && reset_pend) |-> int_lvl == LEVEL_RESET ##1 (state == S_VEC_WP && MEM_OUT.addr == 15'h0000);
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("reset not taken at level zero");

  property p_mask_gate;
    take_int |-> (reset_pend || int_lvl <= mask);
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("interrupt taken below mask");

  property p_load_vec;
    (state == S_VEC_PC && kind == OP_LOAD_TRAP) |-> MEM_OUT.addr == 15'h7FFF;
  endproperty
  a_load_vec: assert property (p_load_vec) else $error("load trap vector address wrong");

  sequence s_save_wp;
    state == S_SAVE_WP && ack && MEM_OUT.we && MEM_OUT.wdata == wp;
  endsequence
  sequence s_save_rest;
    state == S_SAVE_PC && MEM_OUT.wdata == pc && MEM_OUT.addr == $past(MEM_OUT.addr) + 15'h0001;
  endsequence
  property p_save_link;
    s_save_wp |=> s_save_rest;
  endproperty
  a_save_link: assert property (p_save_link) else $error("old context not saved in order");

  property p_branch_only_pc;
    (cmd_go && CMD_IN.op == OP_BRANCH) |=> wp == $past(wp) && pc == $past(CMD_IN.target) && psw == $past(psw);
  endproperty
  a_branch_only_pc: assert property (p_branch_only_pc) else $error("branch touched more than counter");

  property p_restore;
    (ack && state == S_RET_PSW) |=> psw == $past(MEM_RDATA_IN) && wp == $past(new_wp) && pc == $past(new_pc);
  endproperty
  a_restore: assert property (p_restore) else $error("return did not restore context");

  property p_mask_lower;
    (commit && kind == OP_INTERRUPT && lvl != LEVEL_RESET) |=> mask == $past(lvl) - LEVEL_STEP;
  endproperty
  a_mask_lower: assert property (p_mask_lower) else $error("mask not lowered after interrupt");

  property p_index_zero;
    idx_err |=> ERR_OUT && DONE_OUT && state == S_IDLE;
  endproperty
  a_index_zero: assert property (p_index_zero) else $error("register zero used as index");

endmodule
`default_nettype wire

//--- cvu_mem_model.sv
// word-wide memory partner with settable acknowledge delay and a bench back door
`timescale 1ns/1ps
`default_nettype none
module cvu_mem_model
  import cvu_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // memory port
  input wire cvu_pkg::cvu_mem_t mem_in,
  input wire logic [3:0] dly_in,
  output logic ack_out,
  output logic [15:0] rdata_out,
  // back door
  input wire logic bd_we_in,
  input wire logic [14:0] bd_addr_in,
  input wire logic [15:0] bd_wdata_in,
  output logic [15:0] bd_rdata_out
);
  logic [15:0] mem [0:32767];
  logic [15:0] rdq;
  logic [3:0] cnt;
  assign bd_rdata_out = mem[bd_addr_in];
  // released bus shows the inverse, so a stale word never reads back by luck
  assign rdata_out = ack_out ? rdq : ~rdq;
  always @(posedge clk_in)
  begin
    if (bd_we_in)
      mem[bd_addr_in] <= bd_wdata_in;
  end
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ack_out <= 1'b0;
      cnt <= 4'h0;
      rdq <= 16'h0000;
    end
    else if (ack_out)
    begin
      ack_out <= 1'b0;
      cnt <= 4'h0;
    end
    else if (mem_in.req)
    begin
      if (cnt == dly_in)
      begin
        ack_out <= 1'b1;
        rdq <= mem[mem_in.addr];
        if (mem_in.we)
          mem[mem_in.addr] <= mem_in.wdata;
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- cvu_core_bench.sv
// self-checking bench for the context switch and vector unit
`timescale 1ns/1ps
`default_nettype none
module cvu_core_bench;
  import cvu_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  cvu_cmd_t cmd = '0;
  logic [15:0] int_req = 16'h0000;
  logic load_req = 1'b0;
  logic [3:0] dly = 4'h0;
  logic bd_we = 1'b0;
  logic [14:0] bd_addr = 15'h0000;
  logic [15:0] bd_wdata = 16'h0000;
  logic [15:0] bd_rdata;
  cvu_mem_t mem;
  logic ack;
  logic [15:0] rdata;
  logic ready;
  logic done;
  logic err;
  logic got_err;
  logic [15:0] result;
  logic [15:0] wp;
  logic [15:0] pc;
  logic [15:0] psw;
  int err_total = 0;
  int checked = 0;
  int lat;
  always #5 clk = ~clk;
  cvu_core DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd),
    .CMD_READY_OUT(ready), .DONE_OUT(done), .RESULT_OUT(result), .ERR_OUT(err), .INT_REQ_IN(int_req),
    .LOAD_REQ_IN(load_req), .MEM_OUT(mem), .MEM_ACK_IN(ack), .MEM_RDATA_IN(rdata),
    .WORKSPACE_PTR_OUT(wp), .PROGRAM_COUNTER_OUT(pc), .PROCESSOR_STATUS_WORD_OUT(psw));
  cvu_mem_model MEM (.clk_in(clk), .rst_b_in(rst_b), .mem_in(mem), .dly_in(dly), .ack_out(ack),
    .rdata_out(rdata), .bd_we_in(bd_we), .bd_addr_in(bd_addr), .bd_wdata_in(bd_wdata),
    .bd_rdata_out(bd_rdata));
  task automatic stop_test();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic poke(input logic [15:0] a, input logic [15:0] d);
    bd_addr = a[15:1];
    bd_wdata = d;
    bd_we = 1'b1;
    @(posedge clk);
    #1;
    bd_we = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic peek(input logic [15:0] a, input logic [15:0] exp);
    bd_addr = a[15:1];
    @(posedge clk);
    #1;
    cmp(bd_rdata, exp);
  endtask
  // counts cycles to the completion pulse; a branch pulse already stands after the take edge
  task automatic wait_done(input int first);
    lat = first;
    while (done !== 1'b1)
    begin
      @(posedge clk);
      #1;
      lat++;
      if (lat > 300)
      begin
        err_total++;
        stop_test();
      end
    end
    got_err = err;
  endtask
  // an edge passes before valid rises, so it never drops and rises in one step
  task automatic do_cmd(input cvu_op_t op, input logic [15:0] t, input logic [15:0] x, input logic [3:0] nm,
    input logic isr, input logic [3:0] sr);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cmd = '{op, t, x, nm, isr, sr};
    cmd_valid = 1'b1;
    while (ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300)
      begin
        err_total++;
        stop_test();
      end
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    wait_done(1);
  endtask
  task automatic t_reset();
    wait_done(0);
    cmp(wp, 16'h0100);
    cmp(pc, 16'h0200);
    cmp(psw, 16'h0000);
    peek(16'h011C, 16'h0000);
  endtask
  task automatic t_links();
    do_cmd(OP_BRANCH, 16'h0400, 16'h0000, 4'h0, 1'b0, 4'h0);
    cmp(16'(lat), 16'h0001);
    cmp(pc, 16'h0400);
    cmp(wp, 16'h0100);
    do_cmd(OP_BRANCH_AND_LINK, 16'h0480, 16'h0404, 4'h0, 1'b0, 4'h0);
    cmp(pc, 16'h0480);
    peek(16'h0116, 16'h0404);
    poke(16'h0500, 16'h0600);
    poke(16'h0502, 16'h0700);
    dly = 4'h3;
    do_cmd(OP_BRANCH_LOAD_WORKSPACE, 16'h0500, 16'h0000, 4'h0, 1'b0, 4'h0);
    dly = 4'h0;
    cmp(wp, 16'h0600);
    cmp(pc, 16'h0700);
    peek(16'h061A, 16'h0100);
    peek(16'h061C, 16'h0480);
    peek(16'h061E, 16'h0000);
    poke(16'h061E, 16'h000F);
    do_cmd(OP_RETURN_RESTORE_WORKSPACE, 16'h0000, 16'h0000, 4'h0, 1'b0, 4'h0);
    cmp(wp, 16'h0100);
    cmp(pc, 16'h0480);
    cmp(psw, 16'h000F);
  endtask
  // nested traps, register operand then address operand, then unwind
  task automatic t_trap();
    poke(16'h0048, 16'h0800);
    poke(16'h004A, 16'h0900);
    poke(16'h007C, 16'h0880);
    poke(16'h007E, 16'h0990);
    do_cmd(OP_EXTENDED_OPERATION_TRAP, 16'h0000, 16'h0000, 4'h2, 1'b1, 4'h3);
    cmp(wp, 16'h0800);
    peek(16'h0816, 16'h0106);
    peek(16'h081A, 16'h0100);
    do_cmd(OP_EXTENDED_OPERATION_TRAP, 16'h0000, 16'h1357, 4'hF, 1'b0, 4'h0);
    cmp(wp, 16'h0880);
    cmp(pc, 16'h0990);
    peek(16'h0896, 16'h1357);
    peek(16'h089A, 16'h0800);
    do_cmd(OP_RETURN_RESTORE_WORKSPACE, 16'h0000, 16'h0000, 4'h0, 1'b0, 4'h0);
    cmp(pc, 16'h0900);
    do_cmd(OP_RETURN_RESTORE_WORKSPACE, 16'h0000, 16'h0000, 4'h0, 1'b0, 4'h0);
    cmp(wp, 16'h0100);
    cmp(psw, 16'h000F);
  endtask
  task automatic t_data();
    poke(16'h0A00, 16'hABCD);
    poke(16'h0100, 16'h1237);
    poke(16'h010A, 16'h0010);
    do_cmd(OP_BYTE_READ, 16'h0A00, 16'h0000, 4'h0, 1'b0, 4'h0);
    cmp(result, 16'h00AB);
    do_cmd(OP_BYTE_READ, 16'h0A01, 16'h0000, 4'h0, 1'b0, 4'h0);
    cmp(result, 16'h00CD);
    do_cmd(OP_SHIFT_COUNT, 16'h0000, 16'h0000, 4'h0, 1'b0, 4'h0);
    cmp(result, 16'h0007);
    do_cmd(OP_INDEX, 16'h2000, 16'h0000, 4'h5, 1'b0, 4'h0);
    cmp(result, 16'h2010);
    cmp({15'h0000, got_err}, 16'h0000);
    do_cmd(OP_INDEX, 16'h2000, 16'h0000, 4'h0, 1'b0, 4'h0);
    cmp({15'h0000, got_err}, 16'h0001);
  endtask
  // level 5 taken, level 5 again refused, level 4 at the mask taken, load ignores mask
  task automatic t_events();
    poke(16'h0014, 16'h0C00);
    poke(16'h0016, 16'h0D00);
    poke(16'h0010, 16'h0B00);
    poke(16'h0012, 16'h0B80);
    poke(16'hFFFC, 16'h0E00);
    poke(16'hFFFE, 16'h0F00);
    int_req = 16'h0020;
    wait_done(0);
    int_req = 16'h0000;
    cmp(wp, 16'h0C00);
    cmp(pc, 16'h0D00);
    cmp(psw, 16'h0004);
    peek(16'h0C1E, 16'h000F);
    int_req = 16'h0020;
    repeat (20) @(posedge clk);
    #1;
    cmp(wp, 16'h0C00);
    int_req = 16'h0010;
    wait_done(0);
    int_req = 16'h0000;
    cmp(wp, 16'h0B00);
    cmp(psw, 16'h0003);
    peek(16'h0B1A, 16'h0C00);
    load_req = 1'b1;
    wait_done(0);
    load_req = 1'b0;
    cmp(wp, 16'h0E00);
    cmp(pc, 16'h0F00);
    cmp(psw, 16'h0003);
    peek(16'h0E1C, 16'h0B80);
  endtask
  initial
  begin
    poke(16'h0000, 16'h0100);
    poke(16'h0002, 16'h0200);
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_links();
    t_trap();
    t_data();
    t_events();
    stop_test();
  end
endmodule
`default_nettype wire
